//--- inc/sfa_pkg.sv
package sfa_pkg;
	// Register addresses on the special-function register port
	localparam logic [7:0] CTL_ADDR = 8'hC0;
	localparam logic [7:0] DAT_ADDR = 8'hC2;
	localparam logic [7:0] ADR_ADDR = 8'hD7;
	localparam logic [7:0] ADM_ADDR = 8'hE7;

	// Values after reset
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [7:0] DAT_RESET = 8'h00;
	localparam logic [7:0] ADR_RESET = 8'h00;
	localparam logic [7:0] ADM_RESET = 8'hFE;

	// Field positions in bus_control_reg
	localparam int CTL_MASTER = 7;
	localparam int CTL_TX_MODE = 6;
	localparam int CTL_BEGIN = 5;
	localparam int CTL_HALT = 4;
	localparam int CTL_ACKREQ = 3;
	localparam int CTL_ARB_LOST = 2;
	localparam int CTL_ACK = 1;
	localparam int CTL_SI = 0;

	// Field positions in the address and mask registers
	localparam int ADDR_MSB = 7;
	localparam int ADDR_LSB = 1;
	localparam int ADR_GEN_CALL = 0;
	localparam int ADM_HWACK = 0;
	localparam logic [6:0] GENERAL_CALL = 7'h00;

	// Link events, one toggle crossing each
	localparam int EV_START_GEN = 0;
	localparam int EV_STOP_GEN = 1;
	localparam int EV_START_DET = 2;
	localparam int EV_STOP_DET = 3;
	localparam int EV_TX_ACKED = 4;
	localparam int EV_RX_BYTE = 5;
	localparam int EV_ADDR_RX = 6;
	localparam int EV_ACK_CYCLE = 7;
	localparam int EV_ARB_SCL = 8;
	localparam int EV_ARB_SDA = 9;
	localparam int EV_COUNT = 10;

	// Sys-domain levels copied to the link domain
	localparam int LV_SI = 0;
	localparam int LV_HWACK = 1;
	localparam int LV_TX_MODE = 2;
	localparam int LV_ACK = 3;
	localparam int LV_IGNORE = 4;
	localparam int LV_COUNT = 5;
endpackage : sfa_pkg

//--- verilog/sfa_flag_addr.sv
`timescale 1ns/10ps
module sfa_flag_addr (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	input wire logic link_clk,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic seq_start_gen,
	input wire logic seq_stop_gen,
	input wire logic seq_start_det,
	input wire logic seq_stop_det,
	input wire logic seq_tx_acked,
	input wire logic seq_rx_byte,
	input wire logic seq_addr_rx,
	input wire logic seq_ack_cycle,
	input wire logic [7:0] seq_byte,
	input wire logic seq_ack_bit,
	input wire logic seq_ack_phase,
	input wire logic seq_tx_one,
	input wire logic seq_stop_attempt,
	input wire logic seq_scl_low,
	input wire logic seq_sda_low,
	output logic stall_link,
	output logic ignore_link
);
	import sfa_pkg::*;

	// Link domain: pin synchronisers and edge detect
	logic scl_s1, scl_s2, scl_s3;
	logic sda_s1, sda_s2;
	logic stop_try_d;
	logic [7:0] link_byte;
	logic link_ack;
	logic [EV_COUNT-1:0] link_ev;
	logic [EV_COUNT-1:0] link_tog;
	logic [LV_COUNT-1:0] lv_s1, lv_s2;
	logic [LV_COUNT-1:0] sys_lv;
	logic scl_rise, stop_try;

	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_s3 <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
		end else begin
			scl_s1 <= scl_i;
			scl_s2 <= scl_s1;
			scl_s3 <= scl_s2;
			sda_s1 <= sda_i;
			sda_s2 <= sda_s1;
		end
	end

	assign scl_rise = scl_s2 & ~scl_s3;
	assign stop_try = seq_stop_attempt & ~scl_s2;

	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			stop_try_d <= 1'b0;
		end else begin
			stop_try_d <= stop_try;
		end
	end

	always_comb begin
		link_ev = '0;
		link_ev[EV_START_GEN] = seq_start_gen;
		link_ev[EV_STOP_GEN] = seq_stop_gen;
		link_ev[EV_START_DET] = seq_start_det;
		link_ev[EV_STOP_DET] = seq_stop_det;
		link_ev[EV_TX_ACKED] = seq_tx_acked;
		link_ev[EV_RX_BYTE] = seq_rx_byte;
		link_ev[EV_ADDR_RX] = seq_addr_rx;
		link_ev[EV_ACK_CYCLE] = seq_ack_cycle;
		link_ev[EV_ARB_SCL] = stop_try & ~stop_try_d;
		link_ev[EV_ARB_SDA] = scl_rise & seq_tx_one & ~sda_s2;
	end

	// Byte and ack held stable until the next event of their kind
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			link_byte <= 8'h00;
			link_ack <= 1'b1;
		end else begin
			if (seq_rx_byte | seq_addr_rx) begin
				link_byte <= seq_byte;
			end
			if (seq_tx_acked) begin
				link_ack <= seq_ack_bit;
			end
		end
	end

	// Levels from the sys domain, two flops each
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			lv_s1 <= '0;
			lv_s2 <= '0;
		end else begin
			lv_s1 <= sys_lv;
			lv_s2 <= lv_s1;
		end
	end

	// Open-drain drive: enable pulls the wire low
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			stall_link <= 1'b0;
			ignore_link <= 1'b0;
		end else begin
			scl_oe <= seq_scl_low | lv_s2[LV_SI];
			sda_oe <= seq_sda_low | (seq_ack_phase & lv_s2[LV_HWACK] & ~lv_s2[LV_TX_MODE]
				& lv_s2[LV_ACK] & ~lv_s2[LV_IGNORE]);
			stall_link <= lv_s2[LV_SI];
			ignore_link <= lv_s2[LV_IGNORE];
		end
	end

	assign scl_o = 1'b0;
	assign sda_o = 1'b0;

	// Event crossing: toggle in link domain, three flops in sys domain
	logic [EV_COUNT-1:0] tog_s1, tog_s2, tog_s3;
	logic [EV_COUNT-1:0] ev;

	genvar gi;
	generate
		for (gi = 0; gi < EV_COUNT; gi++) begin : g_ev
			always_ff @(posedge link_clk or negedge rst_n) begin
				if (!rst_n) begin
					link_tog[gi] <= 1'b0;
				end else if (link_ev[gi]) begin
					link_tog[gi] <= ~link_tog[gi];
				end
			end
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					tog_s1[gi] <= 1'b0;
					tog_s2[gi] <= 1'b0;
					tog_s3[gi] <= 1'b0;
				end else begin
					tog_s1[gi] <= link_tog[gi];
					tog_s2[gi] <= tog_s1[gi];
					tog_s3[gi] <= tog_s2[gi];
				end
			end
			assign ev[gi] = tog_s2[gi] ^ tog_s3[gi];
		end
	endgenerate

	// Sys domain registers
	logic master, tx_mode, begin_flag, halt_flag, ack_req, arb_lost, ack_flag, si;
	logic [7:0] shift_data, own_addr, addr_mask;
	logic data_written, start_pending, addressed, ignore;
	logic next_si;
	logic ctl_wr, dat_wr;
	logic hw_ack, match, arb_event, stop_arb, rstart_unreq, slave_ok, addr_take, si_fall;

	function automatic logic addr_hit(input logic [7:0] rx, input logic [7:0] adr,
		input logic [7:0] msk);
		logic [6:0] diff;
		diff = (rx[ADDR_MSB:ADDR_LSB] ^ adr[ADDR_MSB:ADDR_LSB]) & msk[ADDR_MSB:ADDR_LSB];
		addr_hit = (diff == 7'h00)
			| (adr[ADR_GEN_CALL] & (rx[ADDR_MSB:ADDR_LSB] == GENERAL_CALL));
	endfunction : addr_hit

	assign ctl_wr = sfr_wr & (sfr_addr == CTL_ADDR);
	assign dat_wr = sfr_wr & (sfr_addr == DAT_ADDR);
	assign hw_ack = addr_mask[ADM_HWACK];
	assign match = addr_hit(link_byte, own_addr, addr_mask);
	assign rstart_unreq = ev[EV_START_DET] & master & ~begin_flag;
	assign stop_arb = ev[EV_STOP_DET] & master;
	assign arb_event = rstart_unreq | stop_arb | ev[EV_ARB_SCL] | ev[EV_ARB_SDA];
	assign slave_ok = master | ~ignore;
	assign addr_take = ev[EV_ADDR_RX] & (master | ~hw_ack | match) & slave_ok;
	assign si_fall = si & ~next_si;

	always_comb begin
		next_si = si;
		if (ctl_wr) begin
			next_si = sfr_wdata[CTL_SI];
		end
		if (ev[EV_START_GEN] | arb_event | (ev[EV_TX_ACKED] & slave_ok)
			| (ev[EV_RX_BYTE] & slave_ok) | addr_take
			| (ev[EV_STOP_DET] & slave_ok)) begin
			next_si = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			si <= CTL_RESET[CTL_SI];
		end else begin
			si <= next_si;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			arb_lost <= CTL_RESET[CTL_ARB_LOST];
		end else if (arb_event) begin
			arb_lost <= 1'b1;
		end else if (si_fall) begin
			arb_lost <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			master <= CTL_RESET[CTL_MASTER];
		end else if (ev[EV_START_GEN]) begin
			master <= 1'b1;
		end else if (ev[EV_STOP_GEN] | arb_event) begin
			master <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_mode <= CTL_RESET[CTL_TX_MODE];
			data_written <= 1'b0;
		end else begin
			if (ev[EV_START_GEN]) begin
				tx_mode <= 1'b1;
			end else if (ev[EV_START_DET] | arb_event) begin
				tx_mode <= 1'b0;
			end else if (si_fall) begin
				tx_mode <= data_written;
			end
			if (dat_wr) begin
				data_written <= 1'b1;
			end else if (si_fall) begin
				data_written <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			begin_flag <= CTL_RESET[CTL_BEGIN];
			start_pending <= 1'b0;
		end else begin
			if (ev[EV_ADDR_RX] & start_pending) begin
				begin_flag <= 1'b1;
			end else if (ctl_wr) begin
				begin_flag <= sfr_wdata[CTL_BEGIN];
			end
			if (ev[EV_START_DET]) begin
				start_pending <= 1'b1;
			end else if (ev[EV_ADDR_RX]) begin
				start_pending <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			halt_flag <= CTL_RESET[CTL_HALT];
		end else if ((ev[EV_STOP_DET] & addressed) | stop_arb) begin
			halt_flag <= 1'b1;
		end else if (ctl_wr) begin
			halt_flag <= sfr_wdata[CTL_HALT];
		end else if (ev[EV_STOP_GEN]) begin
			halt_flag <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_req <= CTL_RESET[CTL_ACKREQ];
		end else if (ev[EV_RX_BYTE] & ~hw_ack & slave_ok) begin
			ack_req <= 1'b1;
		end else if (ev[EV_ACK_CYCLE]) begin
			ack_req <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_flag <= CTL_RESET[CTL_ACK];
		end else if (ev[EV_TX_ACKED]) begin
			ack_flag <= ~link_ack;
		end else if (ev[EV_ADDR_RX] & hw_ack & ~master) begin
			ack_flag <= match;
		end else if (ctl_wr) begin
			ack_flag <= sfr_wdata[CTL_ACK];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			addressed <= 1'b0;
			ignore <= 1'b0;
		end else if (ev[EV_START_DET]) begin
			addressed <= 1'b0;
			ignore <= 1'b0;
		end else if (ev[EV_ADDR_RX] & ~master) begin
			addressed <= ~hw_ack | match;
			ignore <= hw_ack & ~match;
		end else if (ev[EV_STOP_DET]) begin
			addressed <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_data <= DAT_RESET;
			own_addr <= ADR_RESET;
			addr_mask <= ADM_RESET;
		end else begin
			if (ev[EV_RX_BYTE] | ev[EV_ADDR_RX]) begin
				shift_data <= link_byte;
			end else if (dat_wr) begin
				shift_data <= sfr_wdata;
			end
			if (sfr_wr & (sfr_addr == ADR_ADDR)) begin
				own_addr <= sfr_wdata;
			end
			if (sfr_wr & (sfr_addr == ADM_ADDR)) begin
				addr_mask <= sfr_wdata;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd) begin
			case (sfr_addr)
				CTL_ADDR: sfr_rdata <= {master, tx_mode, begin_flag, halt_flag,
					ack_req, arb_lost, ack_flag, si};
				DAT_ADDR: sfr_rdata <= shift_data;
				ADR_ADDR: sfr_rdata <= own_addr;
				ADM_ADDR: sfr_rdata <= addr_mask;
				default: sfr_rdata <= 8'h00;
			endcase
		end
	end

	always_comb begin
		sys_lv = '0;
		sys_lv[LV_SI] = si;
		sys_lv[LV_HWACK] = hw_ack;
		sys_lv[LV_TX_MODE] = tx_mode;
		sys_lv[LV_ACK] = ack_flag;
		sys_lv[LV_IGNORE] = ignore;
	end

	// Checks
	master_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ev[EV_START_GEN] |=> master) else $error("master not set on start");
	master_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(arb_event & ~ev[EV_START_GEN]) |=> !master && arb_lost)
		else $error("master kept after lost arbitration");
	transmit_mode_flag_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(ev[EV_START_DET] & ~ev[EV_START_GEN]) |=> !tx_mode)
		else $error("transmit mode kept after start");
	begin_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(begin_flag && !ctl_wr) |=> begin_flag)
		else $error("begin flag cleared by hardware");
	ackreq_src_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(ack_req) |-> $past(!hw_ack && ev[EV_RX_BYTE]))
		else $error("ack request without received byte");
	ackreq_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(ev[EV_ACK_CYCLE] & ~ev[EV_RX_BYTE]) |=> !ack_req)
		else $error("ack request kept after ack cycle");
	arb_sda_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ev[EV_ARB_SDA] |=> arb_lost && si)
		else $error("sda loss not flagged");
	arb_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		($fell(si) && !$past(arb_event)) |-> !arb_lost)
		else $error("arbitration flag kept after clear");
	ack_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ev[EV_TX_ACKED] |=> ack_flag == !$past(link_ack))
		else $error("ack flag wrong after ack");
	reject_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(ev[EV_ADDR_RX] && hw_ack && !master && !match && !ev[EV_START_DET])
		|=> ignore && !addressed) else $error("rejected address not ignored");
	gcall_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(ev[EV_ADDR_RX] && hw_ack && !master && own_addr[ADR_GEN_CALL] && !ev[EV_START_DET]
		&& link_byte[ADDR_MSB:ADDR_LSB] == GENERAL_CALL) |=> addressed)
		else $error("general call not accepted");
	stall_a: assert property (@(posedge link_clk) disable iff (!rst_n)
		lv_s2[LV_SI] |=> scl_oe && stall_link) else $error("scl not held");

	master_wr_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
		ev[EV_START_GEN] ##[1:200] ev[EV_TX_ACKED]);
	arb_loss_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
		master ##1 arb_event);
	slave_hit_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
		ev[EV_ADDR_RX] && hw_ack && match && !master);
	slave_miss_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(ignore));
endmodule : sfa_flag_addr

//--- verif/sfa_bus_partner.sv
`timescale 1ns/10ps
// Other masters and slaves on the wire: open drain with pull-ups
module sfa_bus_partner (
	input wire logic dut_scl_oe,
	input wire logic dut_sda_oe,
	input wire logic hold_scl,
	input wire logic hold_sda,
	output logic scl,
	output logic sda
);
	// Released wire floats high through the pull-up
	assign scl = !(dut_scl_oe || hold_scl);
	assign sda = !(dut_sda_oe || hold_sda);
endmodule : sfa_bus_partner

//--- verif/sfa_flag_addr_bench.sv
`timescale 1ns/10ps
module sfa_flag_addr_bench;
	import sfa_pkg::*;
	logic sys_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] sfr_rdata;
	logic [7:0] ev = 8'h00;
	logic [7:0] seq_byte = 8'h00;
	logic seq_ack_bit = 1'b1;
	logic seq_tx_one = 1'b0;
	logic seq_ack_phase = 1'b0;
	logic seq_stop_attempt = 1'b0;
	logic hold_scl = 1'b0;
	logic hold_sda = 1'b0;
	logic scl, sda, scl_o, scl_oe, sda_o, sda_oe, stall_link, ignore_link;
	int error_cnt = 0;
	int tests_run = 0;
	// own, mask, gc enable, incoming address, expected match
	localparam logic [22:0] ADDR_TBL [6] = '{
		{7'h34, 7'h7F, 1'b0, 7'h34, 1'b1}, {7'h34, 7'h7F, 1'b0, 7'h35, 1'b0},
		{7'h34, 7'h7E, 1'b0, 7'h35, 1'b1}, {7'h34, 7'h7F, 1'b1, 7'h00, 1'b1},
		{7'h34, 7'h7F, 1'b0, 7'h00, 1'b0}, {7'h70, 7'h73, 1'b0, 7'h7C, 1'b1}};

	always #12.5 sys_clk = ~sys_clk;
	always #24 link_clk = ~link_clk;

	sfa_flag_addr dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
		.link_clk(link_clk), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe), .seq_start_gen(ev[EV_START_GEN]),
		.seq_stop_gen(ev[EV_STOP_GEN]), .seq_start_det(ev[EV_START_DET]),
		.seq_stop_det(ev[EV_STOP_DET]), .seq_tx_acked(ev[EV_TX_ACKED]),
		.seq_rx_byte(ev[EV_RX_BYTE]), .seq_addr_rx(ev[EV_ADDR_RX]),
		.seq_ack_cycle(ev[EV_ACK_CYCLE]), .seq_byte(seq_byte), .seq_ack_bit(seq_ack_bit),
		.seq_ack_phase(seq_ack_phase), .seq_tx_one(seq_tx_one),
		.seq_stop_attempt(seq_stop_attempt),
		.seq_scl_low(1'b0), .seq_sda_low(1'b0), .stall_link(stall_link),
		.ignore_link(ignore_link));

	sfa_bus_partner partner_u (.dut_scl_oe(scl_oe), .dut_sda_oe(sda_oe),
		.hold_scl(hold_scl), .hold_sda(hold_sda), .scl(scl), .sda(sda));

	task automatic finish_test;
		if (error_cnt == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", name, exp, got);
			error_cnt++;
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge sys_clk);
		sfr_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] msk, input logic [7:0] exp,
		input string name);
		@(posedge sys_clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge sys_clk);
		sfr_rd <= 1'b0;
		#1;
		chk(name, exp & msk, sfr_rdata & msk);
	endtask : rd

	// One link pulse, byte and ack bit kept stable afterwards
	task automatic pulse(input int idx, input logic [7:0] b, input logic ab);
		@(posedge link_clk);
		ev <= 8'h01 << idx;
		seq_byte <= b;
		seq_ack_bit <= ab;
		@(posedge link_clk);
		ev <= 8'h00;
		repeat (12) @(posedge sys_clk);
	endtask : pulse

	task automatic settle;
		repeat (12) @(posedge sys_clk);
	endtask : settle

	initial begin
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		rd(CTL_ADDR, 8'hFF, CTL_RESET, "ctl_reset");
		rd(DAT_ADDR, 8'hFF, DAT_RESET, "dat_reset");
		rd(ADR_ADDR, 8'hFF, 8'h00, "adr_reset");
		rd(ADM_ADDR, 8'hFF, 8'hFE, "adm_reset");
		chk("pin_drive", 8'h00, {6'h00, scl_o, sda_o});
		wr(8'hC1, 8'hFF);
		rd(8'hC1, 8'hFF, 8'h00, "unmapped");
		wr(CTL_ADDR, 8'hCC);
		rd(CTL_ADDR, 8'hFF, 8'h00, "ctl_read_only");
		wr(ADR_ADDR, 8'hA5);
		rd(ADR_ADDR, 8'hFF, 8'hA5, "adr_rw");
		// Master start, stall, halt and stop
		pulse(EV_START_GEN, 8'h00, 1'b1);
		rd(CTL_ADDR, 8'hFF, 8'hC1, "ctl_start_gen");
		chk("scl_oe", 8'h01, {7'h00, scl_oe});
		chk("stall_link", 8'h01, {7'h00, stall_link});
		wr(CTL_ADDR, 8'h10);
		settle();
		rd(CTL_ADDR, 8'hFF, 8'h90, "ctl_no_data_write");
		chk("scl_oe_free", 8'h00, {7'h00, scl_oe});
		pulse(EV_STOP_GEN, 8'h00, 1'b1);
		rd(CTL_ADDR, 8'hFF, 8'h00, "ctl_stop_gen");
		// Data write before SI clear keeps transmit mode
		pulse(EV_START_GEN, 8'h00, 1'b1);
		wr(DAT_ADDR, 8'h5A);
		wr(CTL_ADDR, 8'h00);
		settle();
		rd(CTL_ADDR, 8'hC0, 8'hC0, "ctl_data_write");
		rd(DAT_ADDR, 8'hFF, 8'h5A, "dat_rw");
		// SCL low while attempting a stop
		@(posedge link_clk);
		seq_stop_attempt <= 1'b1;
		hold_scl <= 1'b1;
		settle();
		rd(CTL_ADDR, 8'hFF, 8'h05, "ctl_arb_scl");
		@(posedge link_clk);
		seq_stop_attempt <= 1'b0;
		hold_scl <= 1'b0;
		wr(CTL_ADDR, 8'h00);
		settle();
		rd(CTL_ADDR, 8'hFF, 8'h00, "ctl_si_clear");
		// SDA held low while the device sends a one
		@(posedge link_clk);
		seq_tx_one <= 1'b1;
		hold_sda <= 1'b1;
		hold_scl <= 1'b1;
		settle();
		@(posedge link_clk);
		hold_scl <= 1'b0;
		settle();
		rd(CTL_ADDR, 8'h05, 8'h05, "ctl_arb_sda");
		@(posedge link_clk);
		seq_tx_one <= 1'b0;
		hold_sda <= 1'b0;
		wr(CTL_ADDR, 8'h00);
		// Unrequested repeated start as master
		pulse(EV_START_GEN, 8'h00, 1'b1);
		wr(CTL_ADDR, 8'h00);
		pulse(EV_START_DET, 8'h00, 1'b1);
		rd(CTL_ADDR, 8'h85, 8'h05, "ctl_arb_restart");
		wr(CTL_ADDR, 8'h00);
		// Hardware address recognition
		for (int i = 0; i < 6; i++) begin
			logic [22:0] e;
			e = ADDR_TBL[i];
			wr(ADR_ADDR, {e[22:16], e[8]});
			wr(ADM_ADDR, {e[15:9], 1'b1});
			pulse(EV_START_DET, 8'h00, 1'b1);
			pulse(EV_ADDR_RX, {e[7:1], i[0]}, 1'b1);
			rd(CTL_ADDR, 8'h03, {6'h00, e[0], e[0]}, "ctl_addr_match");
			chk("ignore_link", {7'h00, ~e[0]}, {7'h00, ignore_link});
			// Ack cycle of the received address: hardware pulls SDA low on a match
			@(posedge link_clk);
			seq_ack_phase <= 1'b1;
			repeat (2) @(posedge link_clk);
			#1;
			chk("sda_oe", {7'h00, e[0]}, {7'h00, sda_oe});
			@(posedge link_clk);
			seq_ack_phase <= 1'b0;
			wr(CTL_ADDR, 8'h00);
		end
		// Software acknowledge path as slave
		wr(ADM_ADDR, 8'hFE);
		pulse(EV_START_DET, 8'h00, 1'b1);
		pulse(EV_ADDR_RX, 8'h69, 1'b1);
		rd(CTL_ADDR, 8'h21, 8'h21, "ctl_begin");
		wr(CTL_ADDR, 8'h00);
		settle();
		rd(CTL_ADDR, 8'h21, 8'h00, "ctl_begin_clear");
		pulse(EV_RX_BYTE, 8'h3C, 1'b1);
		rd(CTL_ADDR, 8'h09, 8'h09, "ctl_ack_request");
		pulse(EV_ACK_CYCLE, 8'h3C, 1'b1);
		rd(CTL_ADDR, 8'h08, 8'h00, "ctl_ack_cycle");
		wr(CTL_ADDR, 8'h00);
		pulse(EV_TX_ACKED, 8'h3C, 1'b0);
		rd(CTL_ADDR, 8'h03, 8'h03, "ctl_acked");
		wr(CTL_ADDR, 8'h00);
		pulse(EV_TX_ACKED, 8'h3C, 1'b1);
		rd(CTL_ADDR, 8'h03, 8'h01, "ctl_nacked");
		wr(CTL_ADDR, 8'h00);
		pulse(EV_STOP_DET, 8'h3C, 1'b1);
		rd(CTL_ADDR, 8'h11, 8'h11, "ctl_stop_det");
		finish_test();
	end
endmodule : sfa_flag_addr_bench
